// >>> ucsp_pkg.sv
/*
 * ucsp_pkg: constants and carrier types for the serial port clock source
 * selection and fractional prescaler.
 * Assumes one 25 MHz system clock and pins already synchronous to it.
 */
package ucsp_pkg;

    // system clock
    localparam int UCSP_MCLK_HZ = 25_000_000;

    // prescaler ratio fields: integer part m, eighths n
    localparam int UCSP_M_W = 5;
    localparam int UCSP_N_W = 3;
    localparam int UCSP_RATIO_W = UCSP_M_W + UCSP_N_W;
    localparam int UCSP_ACC_W = UCSP_RATIO_W + 1;

    // one input edge is worth eight eighths
    localparam logic [UCSP_ACC_W-1:0] UCSP_EDGE_EIGHTHS = 9'h008;

    // ratio 1 0/8 used when m is programmed as zero
    localparam logic [UCSP_RATIO_W-1:0] UCSP_RATIO_ONE = 8'h08;

    // modem control register: prescaler enable bit position
    localparam int UCSP_MCR_PRESC_BIT = 7;
    localparam logic [7:0] UCSP_MCR_RESET = 8'h00;

    // line rate ceilings in bits per second
    localparam int UCSP_MAX_1X_BPS = 60_000_000;
    localparam int UCSP_MAX_NX_BPS = 15_000_000;

    // prescaler ratio carrier
    typedef struct packed {
        logic [UCSP_M_W-1:0] m;
        logic [UCSP_N_W-1:0] n;
    } ucsp_ratio_s;

    // clocking mode controls
    typedef struct packed {
        logic use_strap_clock;
        logic rx_ext_1x;
        logic tx_ext_1x;
        logic tx_clock_out;
    } ucsp_mode_s;

    // input clock source selection, oscillator or strap pin
    typedef enum logic [0:0] {
        UCSP_SRC_OSC,
        UCSP_SRC_STRAP
    } ucsp_src_e;

endpackage

// >>> ucsp_clock_prescaler.sv
/*
 * ucsp_clock_prescaler: clock source selection, M plus N/8 prescaler,
 * strap-controlled bypass and external 1x bit clock steering.
 * Assumes oscillator, strap and modem pins are synchronous to mclk and
 * that the host holds reset low when it does not use it.
 */
// Function
// - divide selected clock by m plus n/8, from 1 to 31 7/8.
// - strap high bypasses prescaler, strap low enables it; defaults high.
// - every hardware reset loads inverted strap into modem control bit 7.
// - software may take the input clock from the strap pin instead.
// - external receive mode samples data on the far party's 1x clock.
// - transmitter may use 1x clock from ri, and drive nx out on dtr.
// - 60 Mbps 1x and 15 Mbps oversampled ceilings need a faster mclk than 25 MHz.
`timescale 1ns/10ps

module ucsp_clock_prescaler #(
    parameter int M_W = ucsp_pkg::UCSP_M_W,
    parameter int N_W = ucsp_pkg::UCSP_N_W
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic oscillator_input,
    output logic oscillator_output,
    input wire logic clock_source_strap,
    input wire ucsp_pkg::ucsp_ratio_s ratio,
    input wire ucsp_pkg::ucsp_mode_s mode,
    input wire logic mcr_presc_wr,
    input wire logic mcr_presc_wdata,
    output logic mcr_presc_en,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic dtr_level_n,
    input wire logic serial_in,
    output logic dtr_n,
    output logic baud_tick,
    output logic rx_bit_tick,
    output logic rx_bit_data,
    output logic tx_bit_tick
);
    import ucsp_pkg::*;

    function automatic logic rising(input logic now, input logic was);
        rising = now & ~was;
    endfunction

    // m of zero would give a ratio below one, ticking faster than input edges, so treat it as ratio one
    function automatic logic [UCSP_RATIO_W-1:0] eighths(input ucsp_ratio_s r);
        if (r.m == '0) begin
            eighths = UCSP_RATIO_ONE;
        end else begin
            eighths = r;
        end
    endfunction

    ucsp_src_e src;
    logic src_clk;
    logic src_prev_r;
    logic src_edge;
    logic dsr_edge;
    logic ri_edge;
    logic dsr_prev_r;
    logic ri_prev_r;
    logic presc_en_r;
    logic [UCSP_RATIO_W-1:0] ratio8;
    logic [UCSP_ACC_W-1:0] acc_r;
    logic [UCSP_ACC_W-1:0] acc_sum;
    logic [UCSP_ACC_W-1:0] acc_nxt;
    logic div_hit;
    logic baud_nxt;
    logic baud_r;
    logic nx_clk_r;
    logic rx_tick_r;
    logic rx_data_r;
    logic tx_tick_r;
    logic dtr_r;

    // strap pin replaces the crystal path when software asks
    assign src = mode.use_strap_clock ? UCSP_SRC_STRAP : UCSP_SRC_OSC;
    assign src_clk = (src == UCSP_SRC_STRAP) ? clock_source_strap
                                             : oscillator_input;
    assign src_edge = rising(src_clk, src_prev_r);
    assign dsr_edge = rising(dsr_n, dsr_prev_r);
    assign ri_edge = rising(ri_n, ri_prev_r);

    // oscillator output is idle once the strap pin carries the clock
    assign oscillator_output = (src == UCSP_SRC_STRAP) ? 1'b0
                                                       : ~oscillator_input;

    // previous source level for the edge detector
    always_ff @(posedge mclk) begin
        if (reset) begin
            src_prev_r <= 1'b0;
        end else begin
            src_prev_r <= src_clk;
        end
    end

    // 1x clock pins idle high, so reset to one gives no false edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            dsr_prev_r <= 1'b1;
        end else begin
            dsr_prev_r <= dsr_n;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ri_prev_r <= 1'b1;
        end else begin
            ri_prev_r <= ri_n;
        end
    end

    // synchronous reset, so the strap level may be caught in the reset arm
    always_ff @(posedge mclk) begin
        if (reset) begin
            presc_en_r <= ~clock_source_strap;
        end else if (mcr_presc_wr) begin
            presc_en_r <= mcr_presc_wdata;
        end
    end
    assign mcr_presc_en = presc_en_r;

    // ratio in eighths, compared against the accumulator
    assign ratio8 = eighths(ratio);

    // accumulate eighths per input edge, emit a tick each full ratio
    always_comb begin
        acc_sum = acc_r + (src_edge ? UCSP_EDGE_EIGHTHS : '0);
        div_hit = acc_sum >= {1'b0, ratio8};
        acc_nxt = div_hit ? acc_sum - {1'b0, ratio8} : acc_sum;
    end

    // cleared while bypassed, so a re-enable starts from a clean count
    always_ff @(posedge mclk) begin
        if (reset || !presc_en_r) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // bypass gives one tick per input edge, ratio exactly one
    always_comb begin
        if (presc_en_r) begin
            baud_nxt = div_hit;
        end else begin
            baud_nxt = src_edge;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            baud_r <= 1'b0;
        end else begin
            baud_r <= baud_nxt;
        end
    end
    assign baud_tick = baud_r;

    // nx clock level for the dtr pin, toggled on every baud tick
    always_ff @(posedge mclk) begin
        if (reset) begin
            nx_clk_r <= 1'b0;
        end else if (baud_r) begin
            nx_clk_r <= ~nx_clk_r;
        end
    end

    // rx tick on the rising edge of the far party's 1x clock when external, else internal baud tick
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_tick_r <= 1'b0;
        end else if (mode.rx_ext_1x) begin
            rx_tick_r <= dsr_edge;
        end else begin
            rx_tick_r <= baud_r;
        end
    end

    // data held between 1x edges in external mode, so it stands for the whole bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_data_r <= 1'b1;
        end else if (!mode.rx_ext_1x || dsr_edge) begin
            rx_data_r <= serial_in;
        end
    end
    assign rx_bit_tick = rx_tick_r;
    assign rx_bit_data = rx_data_r;

    // tx bit clock from ri when external, else internal baud tick
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_tick_r <= 1'b0;
        end else if (mode.tx_ext_1x) begin
            tx_tick_r <= ri_edge;
        end else begin
            tx_tick_r <= baud_r;
        end
    end
    assign tx_bit_tick = tx_tick_r;

    // clock out is independent of the tx clock source
    always_ff @(posedge mclk) begin
        if (reset) begin
            dtr_r <= 1'b1;
        end else if (mode.tx_clock_out) begin
            dtr_r <= nx_clk_r;
        end else begin
            dtr_r <= dtr_level_n;
        end
    end
    assign dtr_n = dtr_r;

    // limitation: at 25 MHz mclk, external 1x edges must be at least two
    // mclk periods apart, far below the 60 and 15 Mbps device ceilings
    // (UCSP_MAX_1X_BPS, UCSP_MAX_NX_BPS) reached with a faster mclk

endmodule // ucsp_clock_prescaler

// >>> ucsp_peer.sv
/* peer: far-side 1x bit clock and serial data source.
   assumes the bench raises run for a frame and drops it after. */
`timescale 1ns/10ps
module ucsp_peer #(
    parameter logic [7:0] PAT = 8'h4d
) (
    input wire logic mclk,
    input wire logic run,
    output logic bclk_n,
    output logic sdata
);
    logic [4:0] c = 5'h0;
    logic on = 1'b0;
    initial {bclk_n, sdata} = 2'h3;
    // four mclk per bit, so the edge detector never loses a bit
    always @(posedge mclk) begin
        c <= run ? c + 5'h1 : 5'h0;
        if (run) bclk_n <= c[1];
        if (run && c[1:0] == 2'h0) sdata <= PAT[c[4:2]];
        on <= run;
        if (on && !run) sdata <= ~sdata; // released line shows the inverse
    end
endmodule // ucsp_peer

// >>> ucsp_clock_prescaler_sva.sv
/* checker: port assertions for the prescaler, mclk domain.
   assumes the bind below onto ucsp_clock_prescaler. */
`timescale 1ns/10ps
module ucsp_sva (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clock_source_strap,
    input wire ucsp_pkg::ucsp_mode_s mode,
    input wire logic mcr_presc_en,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic dtr_level_n,
    input wire logic serial_in,
    input wire logic dtr_n,
    input wire logic baud_tick,
    input wire logic rx_bit_tick,
    input wire logic rx_bit_data,
    input wire logic tx_bit_tick
);
    import ucsp_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_nx;
        baud_tick && mode.tx_clock_out ##1 mode.tx_clock_out;
    endsequence
    AST_LOAD: assert property ($fell(reset) |->
        mcr_presc_en == !$past(clock_source_strap)) else $error("load");
    AST_GAP: assert property (baud_tick |=> !baud_tick)
        else $error("gap");
    AST_RX1: assert property (mode.rx_ext_1x && $rose(dsr_n) |=>
        rx_bit_tick && rx_bit_data == $past(serial_in)) else $error("rx");
    AST_TX1: assert property (mode.tx_ext_1x && $rose(ri_n) |=>
        tx_bit_tick) else $error("tx");
    AST_RXN: assert property (!mode.rx_ext_1x && baud_tick |=>
        rx_bit_tick) else $error("rxn");
    AST_TXN: assert property (!mode.tx_ext_1x && baud_tick |=>
        tx_bit_tick) else $error("txn");
    AST_LVL: assert property (!mode.tx_clock_out |=>
        dtr_n == $past(dtr_level_n)) else $error("lvl");
    AST_NXO: assert property (s_nx |=> dtr_n != $past(dtr_n))
        else $error("nxo");
endmodule // ucsp_sva
bind ucsp_clock_prescaler ucsp_sva u_sva (.mclk(mclk), .reset(reset),
    .clock_source_strap(clock_source_strap), .mode(mode),
    .mcr_presc_en(mcr_presc_en), .dsr_n(dsr_n), .ri_n(ri_n),
    .dtr_level_n(dtr_level_n), .serial_in(serial_in), .dtr_n(dtr_n),
    .baud_tick(baud_tick), .rx_bit_tick(rx_bit_tick),
    .rx_bit_data(rx_bit_data), .tx_bit_tick(tx_bit_tick));

// >>> ucsp_clock_prescaler_tb.sv
/* testbench: reset, ratios, strap clock and 1x frames.
   assumes ucsp_peer and the bound checker. */
`timescale 1ns/10ps
module ucsp_clock_prescaler_tb;
    import ucsp_pkg::*;
    localparam logic [7:0] PAT = 8'h4d;
    logic mclk = 0, reset = 1, osc = 0, strap = 1, run = 0;
    logic wr = 0, wd = 0, lvl = 0;
    ucsp_ratio_s ratio = 8'h0;
    ucsp_mode_s mode = 4'h0;
    logic en, dtr, bt, rt, rd, bclk, sd, tt, oo;
    int n_mismatch = 0, compares = 0, nb = 0, nt = 0;
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) nb <= nb + bt;
    always @(posedge mclk) nt <= nt + tt;
    ucsp_clock_prescaler DUT (.mclk(mclk), .reset(reset),
        .oscillator_input(osc), .oscillator_output(oo),
        .clock_source_strap(strap), .ratio(ratio), .mode(mode),
        .mcr_presc_wr(wr), .mcr_presc_wdata(wd), .mcr_presc_en(en),
        .dsr_n(bclk), .ri_n(bclk), .dtr_level_n(lvl), .serial_in(sd),
        .dtr_n(dtr), .baud_tick(bt), .rx_bit_tick(rt), .rx_bit_data(rd),
        .tx_bit_tick(tt));
    ucsp_peer #(.PAT(PAT)) peer (.mclk(mclk), .run(run), .bclk_n(bclk),
        .sdata(sd));
    task automatic cyc(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string s, logic [15:0] got, logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", s, exp, got);
        end
    endtask
    task automatic rst(logic s);
        strap = s;
        reset = 1;
        cyc(12);
        reset = 0;
        chk("presc_en", en, !s);
    endtask
    task automatic wr_en(logic v);
        wr = 1;
        wd = v;
        cyc(1);
        wr = 0;
        chk("presc_en", en, v);
    endtask
    // edges four mclk apart, well clear of the two-cycle loss limit
    task automatic div(logic [7:0] r, int e, int exp);
        ratio = r;
        nb = 0;
        nt = 0;
        repeat (e) begin
            {strap, osc} = mode.use_strap_clock ? 2'h2 : 2'h1;
            cyc(2);
            chk("osc_out", oo, mode.use_strap_clock ? 1'h0 : !osc);
            {strap, osc} = 2'h0;
            cyc(2);
            chk("osc_out", oo, mode.use_strap_clock ? 1'h0 : !osc);
        end
        cyc(4);
        chk("baud_ticks", nb, exp);
        chk("tx_ticks", nt, exp);
    endtask
    task automatic ext();
        int i;
        mode = 4'h6;
        run = 1;
        for (int b = 0; b < 8; b++) begin
            for (i = 0; i < 40 && rt !== 1'h1; i++) cyc(1);
            if (i == 40) n_mismatch++;
            if (i == 40) report_and_stop();
            chk("rx_bit", rd, PAT[b]);
            chk("tx_bit", tt, 1'h1);
            cyc(1);
        end
        run = 0;
        chk("dtr_level", dtr, 1'h0);
        lvl = 1;
        cyc(1);
        chk("dtr_level", dtr, 1'h1);
    endtask
    initial begin
        rst(1);
        mode = 4'h1;
        div(8'h10, 10, 10);
        rst(0);
        div(8'h10, 20, 10);
        div(8'h0c, 12, 8);
        div(8'hff, 255, 8);
        wr_en(0);
        div(8'h10, 6, 6);
        wr_en(1);
        div(8'h10, 4, 2);
        mode = 4'h9;
        div(8'h00, 6, 6);
        ext();
        report_and_stop();
    end
endmodule // ucsp_clock_prescaler_tb
